// ===== hw/eptm_pkg.sv
/*
 * Package for the encoder position, turns and marker block: register map,
 * field positions, reset values, encoder type codes and carrier structs.
 * Assumes a single 10 MHz clock domain shared by every user of the package.
 */
package eptm_pkg;

   // ------------------------------------------------------------------
   // Register map (byte addresses, one aligned word each)
   // ------------------------------------------------------------------
   localparam int          ADDR_W          = 8;
   localparam logic [7:0]  OFS_CTRL        = 8'h00;
   localparam logic [7:0]  OFS_MARK_FLAG   = 8'h04;
   localparam logic [7:0]  OFS_TURNS_RATIO = 8'h08;
   localparam logic [7:0]  OFS_POS_REV     = 8'h0c;
   localparam logic [7:0]  OFS_POS_ANGLE   = 8'h10;
   localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h14;
   localparam logic [7:0]  OFS_IRQ_CLEAR   = 8'h18;
   localparam logic [7:0]  OFS_IRQ_ENABLE  = 8'h1c;
   localparam logic [7:0]  OFS_HIDDEN      = 8'h20;

   // ------------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------------
   localparam int          CTRL_INHIBIT    = 0;
   localparam int          CTRL_MODE       = 1;
   localparam int          CTRL_ACFG_EN    = 2;
   localparam int          CTRL_TYPE_LO    = 4;
   localparam int          CTRL_LINROT_LO  = 8;
   localparam int          HIDDEN_LOCK     = 16;
   localparam int          IRQ_W           = 3;
   localparam int          IRQ_MARK        = 0;
   localparam int          IRQ_WRAP        = 1;
   localparam int          IRQ_INIT        = 2;
   localparam logic [7:0]  TURNS_RST       = 8'h10;
   localparam logic [4:0]  TURNS_MAX       = 5'h10;
   localparam logic [15:0] RATIO_VIS_MAX   = 16'h00ff;
   localparam logic [7:0]  RATIO_SAT       = 8'hff;

   // ------------------------------------------------------------------
   // Encoder types and linear/rotary codes
   // ------------------------------------------------------------------
   typedef enum logic [3:0] {
      quadrature_incremental      = 4'h0,
      freq_dir_incremental        = 4'h1,
      fwd_rev_incremental         = 4'h2,
      quadrature_with_commutation = 4'h3,
      freq_dir_with_commutation   = 4'h4,
      fwd_rev_with_commutation    = 4'h5,
      sincos_plain                = 4'h6,
      sincos_with_async_serial    = 4'h7,
      sincos_with_bidir_serial    = 4'h8,
      sincos_with_sync_serial     = 4'h9
   } eptm_enc_type_t;

   localparam logic [1:0]  LINROT_LINEAR   = 2'h0;

   // ------------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [31:0]       wdata;
   } eptm_bus_req_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] delta;
   } eptm_move_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] angle;
      logic [15:0] turns;
   } eptm_abs_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] ratio;
   } eptm_acfg_t;

endpackage

// ===== hw/eptm_core.sv
/*
 * Encoder position accumulator with turns mask and marker handling.
 * Assumes the encoder front end delivers signed angle steps in units of
 * 1/2^32 revolution, all inputs synchronous to mclk, and a register master
 * that follows the one-cycle strobe protocol.
 */
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps

module eptm_core (
   input  wire logic                    mclk,
   input  wire logic                    rst_b,
   input  wire eptm_pkg::eptm_bus_req_t bus_req,
   output logic [31:0]                  bus_rdata,
   input  wire eptm_pkg::eptm_move_t    enc_move,
   input  wire logic                    marker_in,
   input  wire eptm_pkg::eptm_abs_t     abs_pos,
   input  wire eptm_pkg::eptm_acfg_t    acfg,
   output logic [47:0]                  position,
   output logic [15:0]                  cfg_ratio_bits,
   output logic                         irq
);
   import eptm_pkg::*;

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   logic [15:0]         rev_q;
   logic [31:0]         angle_q;
   logic                inhibit_q;
   logic                mode_q;
   logic                acfg_en_q;
   eptm_enc_type_t      type_q;
   logic [1:0]          linrot_q;
   logic                flag_q;
   logic [7:0]          ratio_q;
   logic [15:0]         hidden_q;
   logic                locked_q;
   logic                init_done_q;
   logic                mark_prev_q;
   logic [IRQ_W-1:0]    irq_stat_q;
   logic [IRQ_W-1:0]    irq_en_q;
   logic [31:0]         rdata_q;

   // ------------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------------
   logic                wr_ctrl;
   logic                wr_flag;
   logic                wr_ratio;
   logic                wr_clr;
   logic                wr_en;
   logic                incremental;
   logic                serial_abs;
   logic                lin_serial;
   logic [4:0]          eff_bits;
   logic [15:0]         rev_mask;
   logic                mark_evt;
   logic                abs_load;
   logic [32:0]         angle_sum;
   logic                wrap;
   logic [15:0]         rev_step;
   logic [IRQ_W-1:0]    irq_evt;

   assign wr_ctrl  = bus_req.wr && bus_req.addr == OFS_CTRL;
   assign wr_flag  = bus_req.wr && bus_req.addr == OFS_MARK_FLAG;
   assign wr_ratio = bus_req.wr && bus_req.addr == OFS_TURNS_RATIO;
   assign wr_clr   = bus_req.wr && bus_req.addr == OFS_IRQ_CLEAR;
   assign wr_en    = bus_req.wr && bus_req.addr == OFS_IRQ_ENABLE;

   // Types 0..5 are the incremental families with or without commutation.
   assign incremental = type_q <= fwd_rev_with_commutation;
   assign serial_abs  = type_q >= sincos_with_async_serial &&
                        type_q <= sincos_with_sync_serial;
   assign lin_serial  = serial_abs && linrot_q == LINROT_LINEAR;

   // Linear serial devices hold a ratio in the setting, so no mask applies.
   always_comb begin
      if (lin_serial) begin
         eff_bits = TURNS_MAX;
      end else if (ratio_q > 8'(TURNS_MAX)) begin
         eff_bits = TURNS_MAX;
      end else begin
         eff_bits = ratio_q[4:0];
      end
   end

   // A shift by 16 empties the word, giving a full mask; zero bits give none.
   assign rev_mask = ~(16'hffff << eff_bits);

   // ------------------------------------------------------------------
   // Marker edge detection
   // ------------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         mark_prev_q <= 1'b0;
      end else begin
         mark_prev_q <= marker_in;
      end
   end

   assign mark_evt = marker_in && !mark_prev_q && incremental;

   // Absolute load is taken at most once: on the first report after reset, if a serial type is set then.
   assign abs_load = abs_pos.valid && serial_abs && !init_done_q;

   // ------------------------------------------------------------------
   // Angle accumulation with revolution carry
   // ------------------------------------------------------------------
   assign angle_sum = {1'b0, angle_q} + {enc_move.delta[31], enc_move.delta};
   assign wrap      = enc_move.valid && angle_sum[32];
   // A carry out forward, or a borrow backward, crosses one revolution.
   assign rev_step  = enc_move.delta[31] ? rev_q - 16'h0001
                                         : rev_q + 16'h0001;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         angle_q <= 32'h0000_0000;
      end else if (abs_load) begin
         angle_q <= abs_pos.angle;
      end else if (mark_evt && !inhibit_q) begin
         angle_q <= 32'h0000_0000;
      end else if (enc_move.valid) begin
         angle_q <= angle_sum[31:0];
      end
   end

   // For linear devices the front end scales one revolution to the travel
   // across the configured pole count, so the counter needs no change.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rev_q <= 16'h0000;
      end else if (abs_load) begin
         rev_q <= abs_pos.turns & rev_mask;
      end else if (mark_evt && !inhibit_q && mode_q) begin
         rev_q <= 16'h0000;
      end else if (wrap && !(mark_evt && !inhibit_q)) begin
         rev_q <= rev_step & rev_mask;
      end else begin
         rev_q <= rev_q & rev_mask;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         init_done_q <= 1'b0;
      end else if (abs_pos.valid) begin
         init_done_q <= 1'b1;
      end
   end

   assign position = {rev_q, angle_q};

   // ------------------------------------------------------------------
   // Control register and marker flag
   // ------------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         inhibit_q <= 1'b0;
         mode_q    <= 1'b0;
         acfg_en_q <= 1'b0;
         type_q    <= quadrature_incremental;
         linrot_q  <= 2'h1;
      end else if (wr_ctrl) begin
         inhibit_q <= bus_req.wdata[CTRL_INHIBIT];
         mode_q    <= bus_req.wdata[CTRL_MODE];
         acfg_en_q <= bus_req.wdata[CTRL_ACFG_EN];
         type_q    <= eptm_enc_type_t'(bus_req.wdata[CTRL_TYPE_LO +: 4]);
         linrot_q  <= bus_req.wdata[CTRL_LINROT_LO +: 2];
      end
   end

   // A marker edge in the same cycle as a clearing write still sets it.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         flag_q <= 1'b0;
      end else if (mark_evt) begin
         flag_q <= 1'b1;
      end else if (wr_flag) begin
         flag_q <= bus_req.wdata[0];
      end
   end

   // ------------------------------------------------------------------
   // Turns setting, auto-configured ratio and lock
   // ------------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ratio_q  <= TURNS_RST;
         hidden_q <= 16'h0000;
         locked_q <= 1'b0;
      end else if (acfg.valid && acfg_en_q) begin
         if (acfg.ratio > RATIO_VIS_MAX) begin
            ratio_q  <= RATIO_SAT;
            hidden_q <= acfg.ratio;
            locked_q <= 1'b1;
         end else begin
            ratio_q  <= acfg.ratio[7:0];
            hidden_q <= acfg.ratio;
            locked_q <= 1'b0;
         end
      end else if (wr_ratio && !locked_q) begin
         ratio_q <= bus_req.wdata[7:0];
      end
   end

   // The front end reads the turns bits or the linear ratio from here.
   assign cfg_ratio_bits = locked_q ? hidden_q
                                    : {8'h00, ratio_q};

   // ------------------------------------------------------------------
   // Interrupts
   // ------------------------------------------------------------------
   assign irq_evt[IRQ_MARK] = mark_evt;
   assign irq_evt[IRQ_WRAP] = wrap;
   assign irq_evt[IRQ_INIT] = abs_load;

   genvar gi;
   generate
      for (gi = 0; gi < IRQ_W; gi++) begin : g_irq
         always_ff @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
               irq_stat_q[gi] <= 1'b0;
            end else if (irq_evt[gi]) begin
               irq_stat_q[gi] <= 1'b1;
            end else if (wr_clr && bus_req.wdata[gi]) begin
               irq_stat_q[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         irq_en_q <= '0;
      end else if (wr_en) begin
         irq_en_q <= bus_req.wdata[IRQ_W-1:0];
      end
   end

   assign irq = |(irq_stat_q & irq_en_q);

   // ------------------------------------------------------------------
   // Read port
   // ------------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q <= 32'h0000_0000;
      end else if (bus_req.rd) begin
         case (bus_req.addr)
            OFS_CTRL: begin
               rdata_q <= 32'({linrot_q, type_q, 1'b0,
                               acfg_en_q, mode_q, inhibit_q});
            end
            OFS_MARK_FLAG:   rdata_q <= 32'(flag_q);
            OFS_TURNS_RATIO: rdata_q <= 32'(ratio_q);
            OFS_POS_REV:     rdata_q <= 32'(rev_q);
            OFS_POS_ANGLE:   rdata_q <= angle_q;
            OFS_IRQ_STATUS:  rdata_q <= 32'(irq_stat_q);
            OFS_IRQ_ENABLE:  rdata_q <= 32'(irq_en_q);
            OFS_HIDDEN:      rdata_q <= 32'({locked_q, hidden_q});
            default:         rdata_q <= 32'h0000_0000;
         endcase
      end
   end

   assign bus_rdata = rdata_q;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   AST_FLAG_SET: assert property (
      @(posedge mclk) disable iff (!rst_b)
      mark_evt |=> flag_q ##1 (flag_q || $past(wr_flag)))
      else $error("Marker flag not set after marker event.");

   AST_MARK_RESET: assert property (
      @(posedge mclk) disable iff (!rst_b)
      (mark_evt && !inhibit_q && !abs_load) |=> angle_q == 32'h0000_0000)
      else $error("Marker did not clear the angle.");

   AST_INHIBIT_KEEP: assert property (
      @(posedge mclk) disable iff (!rst_b)
      (mark_evt && inhibit_q && !abs_load && !enc_move.valid)
      |=> angle_q == $past(angle_q) && flag_q)
      else $error("Inhibited marker changed the position.");

   AST_MODE_TURNS: assert property (
      @(posedge mclk) disable iff (!rst_b)
      (mark_evt && !inhibit_q && !abs_load)
      |=> ($past(mode_q) ? rev_q == 16'h0000
                         : rev_q == ($past(rev_q) & $past(rev_mask))))
      else $error("Marker mode handled turns wrongly.");

   AST_TYPE_GATE: assert property (
      @(posedge mclk) disable iff (!rst_b)
      (!incremental && !wr_flag) |=> flag_q == $past(flag_q))
      else $error("Marker acted on a non-incremental type.");

   AST_EDGE_ONCE: assert property (
      @(posedge mclk) disable iff (!rst_b)
      mark_evt |=> !mark_evt)
      else $error("Marker event repeated within one active period.");

   AST_TURNS_ZERO: assert property (
      @(posedge mclk) disable iff (!rst_b)
      (eff_bits == 5'h00 && $stable(eff_bits)) |=> rev_q == 16'h0000)
      else $error("Turns not held at zero.");

   AST_TURNS_MAX: assert property (
      @(posedge mclk) disable iff (!rst_b)
      $stable(rev_mask) |=> (rev_q & ~$past(rev_mask)) == 16'h0000)
      else $error("Turns exceed the masked maximum.");

   AST_WRAP_STEP: assert property (
      @(posedge mclk) disable iff (!rst_b)
      (wrap && !enc_move.delta[31] && !abs_load && !mark_evt)
      |=> rev_q == (($past(rev_q) + 16'h0001) & $past(rev_mask)))
      else $error("Forward revolution did not advance the turns.");

   AST_ACFG_BIG: assert property (
      @(posedge mclk) disable iff (!rst_b)
      (acfg.valid && acfg_en_q && acfg.ratio > RATIO_VIS_MAX)
      |=> ratio_q == RATIO_SAT && hidden_q == $past(acfg.ratio) && locked_q)
      else $error("Oversized ratio not hidden.");

   AST_LOCK_HOLD: assert property (
      @(posedge mclk) disable iff (!rst_b)
      (locked_q && wr_ratio && !acfg.valid) |=> $stable(ratio_q))
      else $error("Locked setting changed by a write.");

   AST_ABS_LOAD: assert property (
      @(posedge mclk) disable iff (!rst_b)
      abs_load |=> angle_q == $past(abs_pos.angle) && init_done_q)
      else $error("Absolute angle not loaded at power-up.");

endmodule

// ===== verif/eptm_enc_model.sv
/*
 * Behavioural encoder front end: angle steps, marker level, absolute
 * reports and auto-configuration results, each driven after a rising edge.
 * Assumes the bench calls one task at a time and only while the bus idles.
 */
`timescale 1ns/1ps

module eptm_enc_model (
   input  wire logic            mclk,
   output eptm_pkg::eptm_move_t enc_move,
   output logic                 marker_in,
   output eptm_pkg::eptm_abs_t  abs_pos,
   output eptm_pkg::eptm_acfg_t acfg
);
   import eptm_pkg::*;

   initial begin
      enc_move  = '0;
      marker_in = 1'b0;
      abs_pos   = '0;
      acfg      = '0;
   end

   // Released payloads show the inverse of the last value, never a stale one.
   task automatic move(input logic [31:0] d);
      enc_move <= '{1'b1, d};
      @(posedge mclk);
      enc_move <= '{1'b0, ~d};
      @(posedge mclk);
   endtask

   task automatic set_marker(input logic v);
      marker_in <= v;
      @(posedge mclk);
   endtask

   task automatic report(input logic [31:0] a, input logic [15:0] t);
      abs_pos <= '{1'b1, a, t};
      @(posedge mclk);
      abs_pos <= '{1'b0, ~a, ~t};
      @(posedge mclk);
   endtask

   task automatic autocfg(input logic [15:0] r);
      acfg <= '{1'b1, r};
      @(posedge mclk);
      acfg <= '{1'b0, ~r};
      @(posedge mclk);
   endtask
endmodule

// ===== verif/eptm_core_tb_top.sv
/*
 * Self-checking bench for the position, turns and marker block.
 * Assumes a 10 MHz mclk and the one-cycle strobe register bus.
 */
`timescale 1ns/1ps

module eptm_core_tb_top;
   import eptm_pkg::*;

   logic          mclk    = 1'b0;
   logic          rst_b   = 1'b0;
   eptm_bus_req_t bus_req = '0;
   logic [31:0]   bus_rdata;
   eptm_move_t    enc_move;
   logic          marker_in;
   eptm_abs_t     abs_pos;
   eptm_acfg_t    acfg;
   logic [47:0]   position;
   logic [15:0]   cfg_ratio_bits;
   logic          irq;
   logic          rd_d    = 1'b0;
   logic [47:0]   exp_q[$];
   logic [31:0]   r;
   logic [15:0]   t;
   logic [7:0]    ua;
   int            n_errors = 0;
   int            checks   = 0;
   int            cycles   = 0;
   localparam logic [31:0] QTR = 32'h4000_0000;

   always #50 mclk = ~mclk;

   eptm_core eptm_core_i (
      .mclk          (mclk),
      .rst_b         (rst_b),
      .bus_req       (bus_req),
      .bus_rdata     (bus_rdata),
      .enc_move      (enc_move),
      .marker_in     (marker_in),
      .abs_pos       (abs_pos),
      .acfg          (acfg),
      .position      (position),
      .cfg_ratio_bits(cfg_ratio_bits),
      .irq           (irq)
   );

   eptm_enc_model eptm_enc_model_i (
      .mclk     (mclk),
      .enc_move (enc_move),
      .marker_in(marker_in),
      .abs_pos  (abs_pos),
      .acfg     (acfg)
   );

   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      if (n_errors == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic bus(input logic w, input logic rd, input logic [7:0] a,
                      input logic [31:0] d);
      bus_req <= '{w, rd, a, d};
      @(posedge mclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, 1'b0, a, d);
      bus(1'b0, 1'b0, 8'h00, 32'h0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back({16'h0000, e});
      bus(1'b0, 1'b1, a, 32'h0);
      bus(1'b0, 1'b0, 8'h00, 32'h0);
   endtask

   task automatic do_reset();
      rst_b <= 1'b0;
      repeat (20) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
   endtask

   // ------------------------------------------------------------------
   // Monitor: read data are checked in the cycle after the read strobe.
   // ------------------------------------------------------------------
   always @(posedge mclk) begin
      rd_d <= bus_req.rd;
      if (rd_d) begin
         check({16'h0000, bus_rdata}, exp_q.pop_front());
      end
   end

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         wrap_up();
      end
   end

   initial begin
      void'($urandom(30733));
      do_reset();
      check(position, 48'h0);
      check({32'h0, cfg_ratio_bits}, 48'h0010);
      rd(OFS_CTRL, 32'h100);
      rd(OFS_MARK_FLAG, 32'h0);
      rd(OFS_TURNS_RATIO, 32'h10);
      ua = 8'h21 + 8'($urandom % 32'hdf);
      rd(ua, 32'h0);
      r = $urandom;
      wr(OFS_IRQ_ENABLE, r);
      rd(OFS_IRQ_ENABLE, {29'h0, r[2:0]});
      // Turns counting, masking and wrapping.
      wr(OFS_TURNS_RATIO, 32'h5);
      wr(OFS_IRQ_ENABLE, 32'h7);
      r = $urandom & 32'h3fff_ffff;
      eptm_enc_model_i.move(r);
      eptm_enc_model_i.move(-r);
      check(position, 48'h0);
      repeat (127) eptm_enc_model_i.move(QTR);
      check(position, {16'd31, 32'hc000_0000});
      rd(OFS_IRQ_STATUS, 32'h2);
      eptm_enc_model_i.move(QTR);
      check(position, 48'h0);
      wr(OFS_IRQ_CLEAR, 32'h7);
      check({47'h0, irq}, 48'h0);
      eptm_enc_model_i.move(-QTR);
      check(position, {16'd31, 32'hc000_0000});
      wr(OFS_TURNS_RATIO, 32'h0);
      @(posedge mclk);
      check(position, {16'd0, 32'hc000_0000});
      eptm_enc_model_i.move(QTR);
      check(position, 48'h0);
      wr(OFS_TURNS_RATIO, 32'd20);
      eptm_enc_model_i.move(-QTR);
      rd(OFS_POS_REV, 32'hffff);
      // Marker handling in both modes and with the reset inhibited.
      wr(OFS_IRQ_CLEAR, 32'h7);
      eptm_enc_model_i.set_marker(1'b1);
      repeat (3) @(posedge mclk);
      check(position, {16'hffff, 32'h0});
      rd(OFS_MARK_FLAG, 32'h1);
      rd(OFS_IRQ_STATUS, 32'h1);
      wr(OFS_MARK_FLAG, 32'h0);
      rd(OFS_MARK_FLAG, 32'h0);
      eptm_enc_model_i.set_marker(1'b0);
      wr(OFS_CTRL, 32'h102);
      eptm_enc_model_i.set_marker(1'b1);
      eptm_enc_model_i.set_marker(1'b0);
      check(position, 48'h0);
      rd(OFS_MARK_FLAG, 32'h1);
      wr(OFS_CTRL, 32'h103);
      wr(OFS_MARK_FLAG, 32'h0);
      eptm_enc_model_i.move(QTR);
      eptm_enc_model_i.set_marker(1'b1);
      eptm_enc_model_i.set_marker(1'b0);
      check(position, {16'h0, QTR});
      rd(OFS_MARK_FLAG, 32'h1);
      wr(OFS_MARK_FLAG, 32'h0);
      wr(OFS_CTRL, 32'h160);
      eptm_enc_model_i.set_marker(1'b1);
      eptm_enc_model_i.set_marker(1'b0);
      check(position, {16'h0, QTR});
      rd(OFS_MARK_FLAG, 32'h0);
      // Absolute load, rotary then linear, once per reset.
      do_reset();
      wr(OFS_CTRL, 32'h180);
      wr(OFS_TURNS_RATIO, 32'h4);
      r = $urandom;
      t = 16'($urandom);
      eptm_enc_model_i.report(r, t);
      check(position, {t & 16'h000f, r});
      eptm_enc_model_i.report(~r, ~t);
      check(position, {t & 16'h000f, r});
      rd(OFS_IRQ_STATUS, 32'h4);
      check({47'h0, irq}, 48'h0);
      wr(OFS_IRQ_ENABLE, 32'h4);
      check({47'h0, irq}, 48'h1);
      do_reset();
      wr(OFS_CTRL, 32'h090);
      wr(OFS_TURNS_RATIO, 32'h3);
      r = $urandom;
      t = 16'($urandom);
      eptm_enc_model_i.report(r, t);
      check(position, {t, r});
      // Oversized auto-configured ratio locks the visible setting.
      wr(OFS_CTRL, 32'h094);
      t = 16'h0100 + 16'($urandom % 32'hff00);
      eptm_enc_model_i.autocfg(t);
      rd(OFS_TURNS_RATIO, 32'hff);
      rd(OFS_HIDDEN, {15'h0, 1'b1, t});
      check({32'h0, cfg_ratio_bits}, {32'h0, t});
      wr(OFS_TURNS_RATIO, 32'h7);
      rd(OFS_TURNS_RATIO, 32'hff);
      eptm_enc_model_i.autocfg(16'd200);
      rd(OFS_TURNS_RATIO, 32'hc8);
      check({32'h0, cfg_ratio_bits}, 48'h00c8);
      wr(OFS_TURNS_RATIO, 32'h7);
      rd(OFS_TURNS_RATIO, 32'h7);
      repeat (2) @(posedge mclk);
      wrap_up();
   end
endmodule
